// >>> uiifc_top.v
// uart interrupt identification and fifo control block
// Notes on behaviour
// [R01] line errors raise top priority code 0110
// [R02] overrun line interrupt clears on status read
// [R03] error interrupt holds until bad chars read
// [R04] non-fifo data ready 0100, clears on read
// [R05] fifo data ready at trigger level
// [R06] four idle char times reassert data ready
// [R07] fifo timeout code 1100 after idle chars
// [R08] timeout clears on read, arrival, receiver reset
// [R09] tx empty code 0010, cleared by write
// [R10] first reader, cpu or dma, clears
// [R11] shared address: read ident, write control
// [R12] other control bits ignored unless enabled
// [R13] software always writes dma bit as one
// [R14] control field layout: tl, dma, clears, enable
// [R15] clears self-clear; control resets to zero
// [R16] clear empties fifo count, not shifter
// [R17] trigger codes select 1,4,8,14 bytes
// [R18] highest pending reported, else 0001
`timescale 1ns/1ps
`default_nettype none
`include "uiifc_map.vh"
module uiifc_top (
  // clock, reset, enable
  input wire clk_i,
  input wire arst_n_i,
  input wire clk_en_i,
  // register port
  input wire [7:0] addr_i,
  input wire [31:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  output reg [31:0] rdata_o,
  // receive path events
  input wire rx_push_i,
  input wire [1:0] rx_push_err_i,
  input wire rx_overrun_i,
  input wire rx_dma_rd_i,
  input wire rx_cpu_rd_i,
  input wire rx_top_err_i,
  input wire receiver_reset_bit_i,
  // transmit path events
  input wire tx_write_i,
  input wire tx_pop_i,
  // fifo control outputs
  output reg fifo_enable_bit_o,
  output reg dma_handshake_bit_o,
  output reg [1:0] rx_trigger_level_o,
  output reg rx_fifo_clear_o,
  output reg tx_fifo_clear_o,
  output reg [4:0] rx_count_o,
  output reg [4:0] tx_count_o,
  // interrupt
  output reg irq_o
);
  // ----------------------------------------
  // functions
  // ----------------------------------------
  function [4:0] trig_bytes;
    input [1:0] sel;
    begin
      case (sel)
        2'h0: trig_bytes = `UIIFC_TL0;
        2'h1: trig_bytes = `UIIFC_TL1;
        2'h2: trig_bytes = `UIIFC_TL2;
        default: trig_bytes = `UIIFC_TL3;
      endcase
    end
  endfunction

  function [4:0] step_count;
    input [4:0] cnt;
    input inc;
    input dec;
    begin
      if (inc && !dec) begin
        step_count = cnt + 5'h01;
      end else if (dec && !inc && cnt != 5'h00) begin
        step_count = cnt - 5'h01;
      end else begin
        step_count = cnt;
      end
    end
  endfunction

  // ----------------------------------------
  // state
  // ----------------------------------------
  reg [2:0] irq_en_q;
  reg [3:0] evt_stat_q;
  reg [3:0] evt_mask_q;
  reg [15:0] char_time_q;
  reg overrun_q;
  reg [4:0] err_cnt_q;
  reg rx_full_q;
  reg thr_full_q;
  reg rearm_q;
  reg [3:0] prev_pend_q;
  reg rxrst_q;
  reg tmo_prev_q;

  wire wr_ident = wr_i && addr_i == `UIIFC_A_IDENT;
  wire rd_lstat = rd_i && addr_i == `UIIFC_A_LSTAT;
  wire rx_rd = rx_cpu_rd_i || rx_dma_rd_i; // R10
  wire rx_clr = rx_fifo_clear_o;
  wire tx_clr = tx_fifo_clear_o;
  wire timed_out;

  // ----------------------------------------
  // pending conditions
  // ----------------------------------------
  wire line_pend = irq_en_q[`UIIFC_IE_LINE] && (overrun_q || err_cnt_q != 5'h00); // R01 R03
  wire rx_level = fifo_enable_bit_o ? (rx_count_o >= trig_bytes(rx_trigger_level_o)) // R05 R17
                                    : rx_full_q; // R04
  wire data_pend = irq_en_q[`UIIFC_IE_RX] && (rx_level || rearm_q); // R06
  wire tout_pend = irq_en_q[`UIIFC_IE_RX] && fifo_enable_bit_o && timed_out; // R07
  wire tx_empty = fifo_enable_bit_o ? (tx_count_o == 5'h00) : !thr_full_q;
  wire thre_pend = irq_en_q[`UIIFC_IE_THRE] && tx_empty; // R09
  wire [3:0] id_code;
  wire [3:0] pend_vec = {thre_pend, tout_pend, data_pend, line_pend};
  wire [3:0] pend_rise = pend_vec & ~prev_pend_q;

  // ----------------------------------------
  // submodules
  // ----------------------------------------
  uiifc_timeout u_tmo (
    .clk_i(clk_i),
    .arst_n_i(arst_n_i),
    .en_i(clk_en_i),
    .active_i(fifo_enable_bit_o && rx_count_o != 5'h00 && !rxrst_q),
    .activity_i(rx_push_i || rx_rd || rx_clr), // R08
    .char_cycles_i(char_time_q),
    .expired_o(timed_out)
  );

  uiifc_prio u_prio (
    .line_i(line_pend),
    .timeout_i(tout_pend),
    .rxdata_i(data_pend),
    .thre_i(thre_pend),
    .code_o(id_code) // R18
  );

  // ----------------------------------------
  // fifo control register
  // ----------------------------------------
  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      fifo_enable_bit_o <= 1'b0; // R15
      dma_handshake_bit_o <= 1'b0;
      rx_trigger_level_o <= 2'h0;
      rx_fifo_clear_o <= 1'b0;
      tx_fifo_clear_o <= 1'b0;
    end else if (clk_en_i) begin
      rx_fifo_clear_o <= 1'b0; // R15
      tx_fifo_clear_o <= 1'b0;
      if (wr_ident) begin // R11
        fifo_enable_bit_o <= wdata_i[`UIIFC_FC_EN];
        // other fields only load while fifos were already enabled
        if (fifo_enable_bit_o) begin // R12
          rx_trigger_level_o <= wdata_i[`UIIFC_FC_TL_HI:`UIIFC_FC_TL_LO]; // R14
          dma_handshake_bit_o <= wdata_i[`UIIFC_FC_DMA]; // R13
          rx_fifo_clear_o <= wdata_i[`UIIFC_FC_RX_FIFO_CLEAR];
          tx_fifo_clear_o <= wdata_i[`UIIFC_FC_TX_FIFO_CLEAR];
        end
      end
    end
  end

  // ----------------------------------------
  // fifo counters and receive status
  // ----------------------------------------
  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rx_count_o <= 5'h00;
      tx_count_o <= 5'h00;
      rx_full_q <= 1'b0;
      thr_full_q <= 1'b0;
      overrun_q <= 1'b0;
      err_cnt_q <= 5'h00;
      rxrst_q <= 1'b0;
    end else if (clk_en_i) begin
      rxrst_q <= !receiver_reset_bit_i;
      // clearing only the counters; the shifters live outside this block
      if (rx_clr || !fifo_enable_bit_o) begin // R16
        rx_count_o <= 5'h00;
      end else begin
        rx_count_o <= step_count(rx_count_o, rx_push_i, rx_rd);
      end
      if (tx_clr || !fifo_enable_bit_o) begin // R16
        tx_count_o <= 5'h00;
      end else begin
        tx_count_o <= step_count(tx_count_o, tx_write_i, tx_pop_i);
      end
      // set wins over clear for the full and overrun flags; the fifo clear still empties the error count
      if (rx_push_i) begin
        rx_full_q <= 1'b1;
      end else if (rx_rd) begin // R04
        rx_full_q <= 1'b0;
      end
      if (tx_write_i) begin // R09
        thr_full_q <= 1'b1;
      end else if (tx_pop_i) begin
        thr_full_q <= 1'b0;
      end
      if (rx_overrun_i) begin // R01
        overrun_q <= 1'b1;
      end else if (rd_lstat) begin // R02
        overrun_q <= 1'b0;
      end
      if (rx_clr) begin
        err_cnt_q <= 5'h00;
      end else begin
        err_cnt_q <= step_count(err_cnt_q, rx_push_i && rx_push_err_i != 2'h0,
                                rx_rd && rx_top_err_i); // R03
      end
    end
  end

  // ----------------------------------------
  // data-ready rearm after idle
  // ----------------------------------------
  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rearm_q <= 1'b0;
      tmo_prev_q <= 1'b0;
    end else if (clk_en_i) begin
      tmo_prev_q <= timed_out;
      // only the expiry edge rearms; a stale expiry must not outlive the access that ends it
      if (timed_out && !tmo_prev_q && fifo_enable_bit_o) begin
        rearm_q <= 1'b1; // R06
      end else if (rx_rd || rx_push_i || rx_clr) begin
        rearm_q <= 1'b0; // R10
      end
    end
  end

  // ----------------------------------------
  // registers, events and interrupt
  // ----------------------------------------
  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      irq_en_q <= 3'h0;
      evt_stat_q <= 4'h0;
      evt_mask_q <= 4'h0;
      char_time_q <= `UIIFC_CHAR_TIME_RST;
      prev_pend_q <= 4'h0;
      rdata_o <= 32'h00000000;
      irq_o <= 1'b0;
    end else if (clk_en_i) begin
      prev_pend_q <= pend_vec;
      // a rising source beats a same-cycle write-one clear
      if (wr_i && addr_i == `UIIFC_A_EVT_STAT) begin
        evt_stat_q <= (evt_stat_q & ~wdata_i[3:0]) | pend_rise;
      end else begin
        evt_stat_q <= evt_stat_q | pend_rise;
      end
      if (wr_i && addr_i == `UIIFC_A_IRQ_EN) begin
        irq_en_q <= wdata_i[2:0];
      end
      if (wr_i && addr_i == `UIIFC_A_EVT_MASK) begin
        evt_mask_q <= wdata_i[3:0];
      end
      if (wr_i && addr_i == `UIIFC_A_CHAR_TIME) begin
        char_time_q <= wdata_i[15:0];
      end
      irq_o <= |(evt_stat_q & evt_mask_q);
      rdata_o <= 32'h00000000;
      if (rd_i) begin
        case (addr_i)
          `UIIFC_A_IDENT: begin // R11
            rdata_o <= {24'h000000, fifo_enable_bit_o ? `UIIFC_ID_FIFO_ON : 2'h0, 2'h0,
                        id_code}; // R18
          end
          `UIIFC_A_IRQ_EN: rdata_o <= {29'h00000000, irq_en_q};
          `UIIFC_A_LSTAT: rdata_o <= {26'h0000000, err_cnt_q != 5'h00, overrun_q,
                                      tx_empty, 1'b0, 1'b0, rx_level};
          `UIIFC_A_EVT_STAT: rdata_o <= {28'h0000000, evt_stat_q};
          `UIIFC_A_EVT_MASK: rdata_o <= {28'h0000000, evt_mask_q};
          `UIIFC_A_CHAR_TIME: rdata_o <= {16'h0000, char_time_q};
          default: rdata_o <= 32'h00000000;
        endcase
      end
    end
  end
endmodule
`default_nettype wire

// >>> uiifc_map.vh
// register map and constants for the uart interrupt identification and fifo control block
`ifndef UIIFC_MAP_VH
`define UIIFC_MAP_VH
// ----------------------------------------
// register addresses (byte, word aligned)
// ----------------------------------------
`define UIIFC_ADDR_W 8
`define UIIFC_A_IDENT 8'h08
`define UIIFC_A_LSTAT 8'h14
`define UIIFC_A_IRQ_EN 8'h04
`define UIIFC_A_EVT_STAT 8'h40
`define UIIFC_A_EVT_MASK 8'h44
`define UIIFC_A_CHAR_TIME 8'h48
// ----------------------------------------
// fifo control fields
// ----------------------------------------
`define UIIFC_FC_EN 0
`define UIIFC_FC_RX_FIFO_CLEAR 1
`define UIIFC_FC_TX_FIFO_CLEAR 2
`define UIIFC_FC_DMA 3
`define UIIFC_FC_TL_LO 6
`define UIIFC_FC_TL_HI 7
// ----------------------------------------
// identification codes (bits 3..0) and fifo-on value (bits 7..6)
// ----------------------------------------
`define UIIFC_ID_NONE 4'h1
`define UIIFC_ID_LINE 4'h6
`define UIIFC_ID_RXDATA 4'h4
`define UIIFC_ID_TIMEOUT 4'hC
`define UIIFC_ID_THRE 4'h2
`define UIIFC_ID_FIFO_ON 2'h3
// ----------------------------------------
// irq enable bits
// ----------------------------------------
`define UIIFC_IE_RX 0
`define UIIFC_IE_THRE 1
`define UIIFC_IE_LINE 2
// ----------------------------------------
// trigger levels and timeout
// ----------------------------------------
`define UIIFC_TL0 5'h01
`define UIIFC_TL1 5'h04
`define UIIFC_TL2 5'h08
`define UIIFC_TL3 5'h0E
`define UIIFC_CHAR_TIMES 3'h4
`define UIIFC_CHAR_TIME_RST 16'h0457
`define UIIFC_CNT_W 5
`endif

// >>> uiifc_timeout.v
// idle timer that flags four character times of receive fifo inactivity
`timescale 1ns/1ps
`default_nettype none
`include "uiifc_map.vh"
module uiifc_timeout (
  // clock and reset
  input wire clk_i,
  input wire arst_n_i,
  input wire en_i,
  // control
  input wire active_i,
  input wire activity_i,
  input wire [15:0] char_cycles_i,
  // result
  output reg expired_o
);
  reg [15:0] cyc_q;
  reg [2:0] chars_q;

  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cyc_q <= 16'h0000;
      chars_q <= 3'h0;
      expired_o <= 1'b0;
    end else if (en_i) begin
      if (!active_i || activity_i) begin
        cyc_q <= 16'h0000;
        chars_q <= 3'h0;
        expired_o <= 1'b0;
      end else if (!expired_o) begin
        if (cyc_q >= char_cycles_i) begin
          cyc_q <= 16'h0000;
          chars_q <= chars_q + 3'h1;
          if (chars_q + 3'h1 == `UIIFC_CHAR_TIMES) begin
            expired_o <= 1'b1;
          end
        end else begin
          cyc_q <= cyc_q + 16'h0001;
        end
      end
    end
  end
endmodule
`default_nettype wire

// >>> uiifc_prio.v
// priority encoder producing the interrupt identification code
`timescale 1ns/1ps
`default_nettype none
`include "uiifc_map.vh"
module uiifc_prio (
  // pending sources
  input wire line_i,
  input wire timeout_i,
  input wire rxdata_i,
  input wire thre_i,
  // code
  output reg [3:0] code_o
);
  always @* begin
    if (line_i) begin
      code_o = `UIIFC_ID_LINE;
    end else if (timeout_i) begin
      code_o = `UIIFC_ID_TIMEOUT;
    end else if (rxdata_i) begin
      code_o = `UIIFC_ID_RXDATA;
    end else if (thre_i) begin
      code_o = `UIIFC_ID_THRE;
    end else begin
      code_o = `UIIFC_ID_NONE;
    end
  end
endmodule
`default_nettype wire

// >>> uiifc_dma_model.sv
// dma reader model: pops one receive entry per request while the handshake bit is on
`timescale 1ns/1ps
`default_nettype none
module uiifc_dma_model (
  // clock and reset
  input wire logic clk_i,
  input wire logic arst_n_i,
  // request and device state
  input wire logic req_i,
  input wire logic dma_en_i,
  input wire logic [4:0] rx_count_i,
  // read strobe into the device
  output logic rd_o
);
  // never strobes an empty fifo, one strobe per request
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rd_o <= 1'b0;
    end else begin
      rd_o <= req_i && dma_en_i && (rx_count_i != 5'h00) && !rd_o;
    end
  end
endmodule
`default_nettype wire

// >>> uiifc_top_properties.sv
// checker for the register port and the fifo control outputs
`timescale 1ns/1ps
`default_nettype none
`include "uiifc_map.vh"
module uiifc_chk (
  // clock and reset
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic clk_en_i,
  // register port
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [31:0] rdata_o,
  // fifo control
  input wire logic fifo_enable_bit_o,
  input wire logic dma_handshake_bit_o,
  input wire logic [1:0] rx_trigger_level_o,
  input wire logic rx_fifo_clear_o,
  input wire logic tx_fifo_clear_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);
  wire wr_id = clk_en_i && wr_i && addr_i == `UIIFC_A_IDENT;
  wire rd_id = clk_en_i && rd_i && addr_i == `UIIFC_A_IDENT;
  wire rx_ok = wr_id && fifo_enable_bit_o && wdata_i[1];
  wire tx_ok = wr_id && fifo_enable_bit_o && wdata_i[2];
  wire [1:0] w_tl = wdata_i[7:6];
  wire w_dma = wdata_i[3];
  property p_rx_fifo_clear_set;
    rx_ok |=> rx_fifo_clear_o;
  endproperty
  a_rx_fifo_clear_set: assert property (p_rx_fifo_clear_set) else $error("rx clear missing");
  property p_rx_fifo_clear_cause;
    rx_fifo_clear_o |-> $past(rx_ok);
  endproperty
  a_rx_fifo_clear_cause: assert property (p_rx_fifo_clear_cause) else $error("rx clear uncaused");
  property p_tx_fifo_clear_set;
    tx_ok |=> tx_fifo_clear_o;
  endproperty
  a_tx_fifo_clear_set: assert property (p_tx_fifo_clear_set) else $error("tx clear missing");
  property p_tx_fifo_clear_cause;
    tx_fifo_clear_o |-> $past(tx_ok);
  endproperty
  a_tx_fifo_clear_cause: assert property (p_tx_fifo_clear_cause) else $error("tx clear uncaused");
  property p_fields;
    wr_id && fifo_enable_bit_o |=> rx_trigger_level_o == $past(w_tl)
      && dma_handshake_bit_o == $past(w_dma);
  endproperty
  a_fields: assert property (p_fields) else $error("control fields wrong");
  property p_ignored;
    wr_id && !fifo_enable_bit_o |=> $stable(rx_trigger_level_o) && $stable(dma_handshake_bit_o);
  endproperty
  a_ignored: assert property (p_ignored) else $error("write not ignored");
  property p_rd_idle;
    clk_en_i && !rd_i |=> rdata_o == 32'h0;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside slot");
  property p_ident_fmt;
    rd_id |=> rdata_o[31:8] == 24'h0 && rdata_o[5:4] == 2'h0
      && rdata_o[7:6] == {2{$past(fifo_enable_bit_o)}};
  endproperty
  a_ident_fmt: assert property (p_ident_fmt) else $error("ident format wrong");
  property p_ident_code;
    rd_id |=> rdata_o[3:0] inside {4'h1, 4'h6, 4'h4, 4'hC, 4'h2};
  endproperty
  a_ident_code: assert property (p_ident_code) else $error("ident code illegal");
  c_clear: cover property (rx_fifo_clear_o && tx_fifo_clear_o);
  c_timeout: cover property (rd_id ##1 rdata_o[3:0] == 4'hC);
  c_ignored: cover property (wr_id && !fifo_enable_bit_o);
endmodule
bind uiifc_top uiifc_chk i_chk (.clk_i(clk_i), .arst_n_i(arst_n_i), .clk_en_i(clk_en_i),
  .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
  .fifo_enable_bit_o(fifo_enable_bit_o), .dma_handshake_bit_o(dma_handshake_bit_o),
  .rx_trigger_level_o(rx_trigger_level_o), .rx_fifo_clear_o(rx_fifo_clear_o),
  .tx_fifo_clear_o(tx_fifo_clear_o));
`default_nettype wire

// >>> testbench.sv
// self-checking bench for the interrupt identification and fifo control block
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clk_i, arst_n_i, wr_i, rd_i, top_err, rrst, dreq, drd;
  logic fen, dma, rclr, tclr, irq, cen;
  logic [4:0] txc;
  logic [7:0] addr_i;
  logic [31:0] wdata_i, rdata_o, d;
  logic [4:0] ev, rxc;
  logic [1:0] perr, tl;
  int n_fail = 0;
  int total_checks = 0;
  int lv[4] = '{1, 4, 8, 14};
  uiifc_top i_dut (.clk_i(clk_i), .arst_n_i(arst_n_i), .clk_en_i(cen), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .rx_push_i(ev[0]),
    .rx_push_err_i(perr), .rx_overrun_i(ev[1]), .rx_dma_rd_i(drd), .rx_cpu_rd_i(ev[2]),
    .rx_top_err_i(top_err), .receiver_reset_bit_i(rrst), .tx_write_i(ev[3]),
    .tx_pop_i(ev[4]), .fifo_enable_bit_o(fen), .dma_handshake_bit_o(dma),
    .rx_trigger_level_o(tl), .rx_fifo_clear_o(rclr), .tx_fifo_clear_o(tclr),
    .rx_count_o(rxc), .tx_count_o(txc), .irq_o(irq));
  uiifc_dma_model i_dma (.clk_i(clk_i), .arst_n_i(arst_n_i), .req_i(dreq), .dma_en_i(dma),
    .rx_count_i(rxc), .rd_o(drd));
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  // ----------------------------------------
  // access tasks
  // ----------------------------------------
  task test_done;
    $display("checks=%0d fails=%0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task chk(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      n_fail++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= v;
    @(posedge clk_i);
    wr_i <= 1'b0;
    #1;
  endtask
  task rd(input logic [7:0] a);
    @(posedge clk_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1;
    d = rdata_o;
  endtask
  task rdc(input logic [7:0] a, input logic [31:0] e);
    rd(a);
    chk(d, e);
  endtask
  // one event strobe; bit 0 push, 1 overrun, 2 cpu read, 3 tx write, 4 tx pop
  task pulse(input int b, input logic [1:0] e);
    @(posedge clk_i);
    ev <= 5'h01 << b;
    perr <= e;
    @(posedge clk_i);
    ev <= 5'h00;
    perr <= 2'h0;
    #1;
  endtask
  task wait_id(input logic [31:0] e);
    int i;
    i = 0;
    d = 32'h0;
    while (d !== e && i < 80) begin
      rd(8'h08);
      i++;
    end
    chk(d, e);
    if (d !== e) test_done();
  endtask
  task dma_rd;
    @(posedge clk_i);
    dreq <= 1'b1;
    @(posedge clk_i);
    dreq <= 1'b0;
    repeat (2) @(posedge clk_i);
    #1;
  endtask
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    int k;
    int j;
    arst_n_i = 1'b0;
    {wr_i, rd_i, top_err, dreq} = 4'h0;
    cen = 1'b1;
    rrst = 1'b1;
    addr_i = 8'h00;
    wdata_i = 32'h0;
    ev = 5'h00;
    perr = 2'h0;
    repeat (6) @(posedge clk_i);
    arst_n_i <= 1'b1;
    #1;
    chk({fen, dma, tl, rclr, tclr, irq}, 32'h0);
    rdc(8'h08, 32'h01);
    wr(8'h08, 32'hCE);
    chk({fen, dma, rclr, tl}, 32'h0);
    wr(8'h08, 32'h09);
    rdc(8'h08, 32'hC1);
    wr(8'h08, 32'h4F);
    chk({tl, dma, tclr, rclr}, 32'h0F);
    #10;
    chk({tclr, rclr}, 32'h0);
    wr(8'h04, 32'h07);
    rdc(8'h08, 32'hC2);
    pulse(3, 2'h0);
    chk(txc, 32'h1);
    rdc(8'h08, 32'hC1);
    for (k = 0; k < 4; k++) begin
      wr(8'h08, {k[1:0], 6'h0B});
      #10;
      chk(rxc, 32'h0);
      for (j = 1; j < lv[k]; j++) pulse(0, 2'h0);
      rdc(8'h08, 32'hC1);
      pulse(0, 2'h0);
      chk(rxc, lv[k]);
      rdc(8'h08, 32'hC4);
    end
    pulse(2, 2'h0);
    rdc(8'h08, 32'hC1);
    wr(8'h08, 32'h0B);
    pulse(0, 2'h0);
    dma_rd();
    rdc(8'h08, 32'hC1);
    wr(8'h48, 32'h03);
    wr(8'h08, 32'h4B);
    pulse(0, 2'h0);
    wait_id(32'hCC);
    pulse(0, 2'h0);
    rdc(8'h08, 32'hC1);
    wait_id(32'hCC);
    pulse(2, 2'h0);
    rdc(8'h08, 32'hC1);
    wait_id(32'hCC);
    @(posedge clk_i);
    rrst <= 1'b0;
    @(posedge clk_i);
    rdc(8'h08, 32'hC4);
    @(posedge clk_i);
    rrst <= 1'b1;
    wr(8'h08, 32'h0B);
    pulse(1, 2'h0);
    rdc(8'h08, 32'hC6);
    rd(8'h14);
    rdc(8'h08, 32'hC1);
    pulse(0, 2'h1);
    pulse(0, 2'h0);
    rdc(8'h08, 32'hC6);
    @(posedge clk_i);
    top_err <= 1'b1;
    pulse(2, 2'h0);
    @(posedge clk_i);
    top_err <= 1'b0;
    rdc(8'h08, 32'hC4);
    pulse(2, 2'h0);
    @(posedge clk_i);
    cen <= 1'b0;
    pulse(0, 2'h0);
    chk(rxc, 32'h0);
    @(posedge clk_i);
    cen <= 1'b1;
    wr(8'h40, 32'h0F);
    wr(8'h44, 32'h08);
    chk(irq, 32'h0);
    pulse(4, 2'h0);
    #20;
    chk(irq, 32'h1);
    rdc(8'h40, 32'h08);
    wr(8'h44, 32'h00);
    #10;
    chk(irq, 32'h0);
    wr(8'h44, 32'h08);
    wr(8'h40, 32'h08);
    #10;
    chk(irq, 32'h0);
    wr(8'h08, 32'h08);
    pulse(0, 2'h0);
    rdc(8'h08, 32'h04);
    pulse(2, 2'h0);
    rdc(8'h08, 32'h02);
    rdc(8'h7C, 32'h0);
    test_done();
  end
endmodule
`default_nettype wire
